/* File: include/uesf_defs_defs.vh */
// Constants for the USB event status and mask registers.
// Assumes a 32-bit APB bus; each register sits in one aligned word.
`ifndef UESF_DEFS_DEFS_VH
`define UESF_DEFS_DEFS_VH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define UESF_IDX_STATUS     16'h_fffe
`define UESF_IDX_MASK       16'h_fffd

// ----------------------------------------------------------------------
// Field positions of the status and mask registers.
// ----------------------------------------------------------------------
`define UESF_BIT_OVERWRITE  0
`define UESF_BIT_WAKEUP     1
`define UESF_BIT_SETUP      2
`define UESF_BIT_RI         3
`define UESF_BIT_RSV        4
`define UESF_BIT_RESUME     5
`define UESF_BIT_SUSPEND    6
`define UESF_BIT_RESET      7

// ----------------------------------------------------------------------
// Reset values and bit masks.
// ----------------------------------------------------------------------
`define UESF_RST_STATUS     8'h_00
`define UESF_RST_MASK       8'h_00
`define UESF_IMPL_BITS      8'h_ef

`endif

/* File: hw/uesf_status.v */
// USB event status flags with interrupt mask, reached over APB.
// Assumes event inputs are one-cycle pulses synchronous to pclk, and
// the ring-indicate input a level already synchronous to pclk.
//
// Summary of operation
// - Hardware sets flags; writing 1 clears a flag, writing 0 leaves it.
// - A set flag with its mask bit 1 raises the interrupt output.
// - A received SETUP transaction sets the setup flag, bit 2.
// - While the setup flag is 1, endpoint 0 IN and OUT get NAK.
// - A rising edge of ring indicate sets bit 3, used for wake-up.
// - A global or selective suspend sets the suspend flag, bit 6.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "uesf_defs_defs.vh"

module uesf_status #(
    parameter ADDR_W = 18
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire              setup_rcvd,
    input  wire              remote_wakeup_evt,
    input  wire              ring_indicate,
    input  wire              resume_evt,
    input  wire              suspend_evt,
    input  wire              port_reset_evt,
    output wire              ep0_force_nak,
    output wire              ring_wake,
    output wire              irq
);

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------
    localparam [ADDR_W-1:0] ADDR_STATUS = {`UESF_IDX_STATUS, 2'b00};
    localparam [ADDR_W-1:0] ADDR_MASK   = {`UESF_IDX_MASK, 2'b00};

    localparam [7:0]        RST_STATUS  = `UESF_RST_STATUS;

    wire [7:0] usb_event_status_q;
    reg  [7:0] usb_event_mask_q;
    reg        ri_prev_q;
    reg  [7:0] set_vec;
    reg  [7:0] clr_vec;

    wire hit_status = (paddr == ADDR_STATUS);
    wire hit_mask   = (paddr == ADDR_MASK);
    wire mapped     = hit_status | hit_mask;
    wire access     = psel & penable;
    wire wr_status  = access & pwrite & hit_status;
    wire wr_mask    = access & pwrite & hit_mask;

    // The slave never stalls; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ------------------------------------------------------------------
    // Event collection and flag update.
    // ------------------------------------------------------------------
    // Set terms win over a write-one clear in the same cycle, so an event
    // landing during a clear is never lost.
    always @* begin
        set_vec = 8'h_00;
        set_vec[`UESF_BIT_OVERWRITE] = setup_rcvd & usb_event_status_q[`UESF_BIT_SETUP];
        set_vec[`UESF_BIT_WAKEUP]  = remote_wakeup_evt;
        set_vec[`UESF_BIT_SETUP]   = setup_rcvd;
        set_vec[`UESF_BIT_RI]      = ring_indicate & ~ri_prev_q;
        set_vec[`UESF_BIT_RESUME]  = resume_evt;
        set_vec[`UESF_BIT_SUSPEND] = suspend_evt;
        set_vec[`UESF_BIT_RESET]   = port_reset_evt;
        clr_vec = wr_status ? pwdata[7:0] : 8'h_00;
    end

    // ------------------------------------------------------------------
    // One sticky flag cell per implemented status bit.
    // ------------------------------------------------------------------
    // The reserved bit has no cell, so it reads 0 and ignores writes.
    assign usb_event_status_q[`UESF_BIT_RSV] = 1'b0;

    uesf_flag_bit #(
        .RST_VAL (RST_STATUS[`UESF_BIT_OVERWRITE])
    ) u_flag_overwrite (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (set_vec[`UESF_BIT_OVERWRITE]),
        .clr_req (clr_vec[`UESF_BIT_OVERWRITE]),
        .flag_q  (usb_event_status_q[`UESF_BIT_OVERWRITE])
    );

    uesf_flag_bit #(
        .RST_VAL (RST_STATUS[`UESF_BIT_WAKEUP])
    ) u_flag_wakeup (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (set_vec[`UESF_BIT_WAKEUP]),
        .clr_req (clr_vec[`UESF_BIT_WAKEUP]),
        .flag_q  (usb_event_status_q[`UESF_BIT_WAKEUP])
    );

    uesf_flag_bit #(
        .RST_VAL (RST_STATUS[`UESF_BIT_SETUP])
    ) u_flag_setup (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (set_vec[`UESF_BIT_SETUP]),
        .clr_req (clr_vec[`UESF_BIT_SETUP]),
        .flag_q  (usb_event_status_q[`UESF_BIT_SETUP])
    );

    uesf_flag_bit #(
        .RST_VAL (RST_STATUS[`UESF_BIT_RI])
    ) u_flag_ring (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (set_vec[`UESF_BIT_RI]),
        .clr_req (clr_vec[`UESF_BIT_RI]),
        .flag_q  (usb_event_status_q[`UESF_BIT_RI])
    );

    uesf_flag_bit #(
        .RST_VAL (RST_STATUS[`UESF_BIT_RESUME])
    ) u_flag_resume (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (set_vec[`UESF_BIT_RESUME]),
        .clr_req (clr_vec[`UESF_BIT_RESUME]),
        .flag_q  (usb_event_status_q[`UESF_BIT_RESUME])
    );

    uesf_flag_bit #(
        .RST_VAL (RST_STATUS[`UESF_BIT_SUSPEND])
    ) u_flag_suspend (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (set_vec[`UESF_BIT_SUSPEND]),
        .clr_req (clr_vec[`UESF_BIT_SUSPEND]),
        .flag_q  (usb_event_status_q[`UESF_BIT_SUSPEND])
    );

    uesf_flag_bit #(
        .RST_VAL (RST_STATUS[`UESF_BIT_RESET])
    ) u_flag_bus_reset (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (set_vec[`UESF_BIT_RESET]),
        .clr_req (clr_vec[`UESF_BIT_RESET]),
        .flag_q  (usb_event_status_q[`UESF_BIT_RESET])
    );

    // Mask and the ring-indicate edge history.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_event_mask_q   <= `UESF_RST_MASK;
            ri_prev_q          <= 1'b0;
        end else begin
            ri_prev_q          <= ring_indicate;
            if (wr_mask) begin
                usb_event_mask_q <= pwdata[7:0] & `UESF_IMPL_BITS;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data, loaded in the setup cycle so it is steady in access.
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h_0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            if (hit_status) begin
                prdata <= {24'h_00_0000, usb_event_status_q};
            end else if (hit_mask) begin
                prdata <= {24'h_00_0000, usb_event_mask_q};
            end else begin
                prdata <= 32'h_0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs to the endpoint logic, wake-up logic and the processor.
    // ------------------------------------------------------------------
    // The forced NAK overrides whatever the endpoint 0 NAK bits say.
    assign ep0_force_nak = usb_event_status_q[`UESF_BIT_SETUP];
    assign ring_wake     = usb_event_status_q[`UESF_BIT_RI];
    assign irq           = |(usb_event_status_q & usb_event_mask_q);

endmodule // uesf_status

// ----------------------------------------------------------------------
// Sticky flag cell: set by a hardware event, cleared by a write of one.
// ----------------------------------------------------------------------
// The set term is tested first, so an event that lands in the same cycle
// as a clear keeps the flag up and the event is never lost.
module uesf_flag_bit #(
    parameter RST_VAL = 1'b0
) (
    input  wire pclk,
    input  wire presetn,
    input  wire set_evt,
    input  wire clr_req,
    output reg  flag_q
);

    // Flag storage with set priority over clear.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= RST_VAL;
        end else if (set_evt) begin
            flag_q <= 1'b1;
        end else if (clr_req) begin
            flag_q <= 1'b0;
        end
    end

endmodule // uesf_flag_bit

/* File: testbench/uesf_status_assertions.sv */
// Checker for the event status block; sees only the top module's ports.
`timescale 1ns/100ps
`include "uesf_defs_defs.vh"
module uesf_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        setup_rcvd,
    input wire logic        ring_indicate,
    input wire logic        remote_wakeup_evt,
    input wire logic        resume_evt,
    input wire logic        suspend_evt,
    input wire logic        port_reset_evt,
    input wire logic        ep0_force_nak,
    input wire logic        ring_wake,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A completed write; flags may only fall on one.
    wire wr = psel && penable && pwrite;
    // A completed write to the status register; only it may clear a flag.
    wire wr_st = wr && (paddr == {`UESF_IDX_STATUS, 2'b00});
    wire ev = setup_rcvd || remote_wakeup_evt || resume_evt || suspend_evt || port_reset_evt;
    property p_set_nak; setup_rcvd |=> ep0_force_nak; endproperty
    a_set_nak: assert property (p_set_nak) else $error("setup flag not set");
    property p_hold_nak; ep0_force_nak && !(wr_st && pwdata[2]) |=> ep0_force_nak; endproperty
    a_hold_nak: assert property (p_hold_nak) else $error("nak dropped early");
    property p_clr_nak; $fell(ep0_force_nak) |-> $past(wr_st && pwdata[2]); endproperty
    a_clr_nak: assert property (p_clr_nak) else $error("setup flag lost");
    property p_clr_wake; $fell(ring_wake) |-> $past(wr_st && pwdata[3]); endproperty
    a_clr_wake: assert property (p_clr_wake) else $error("ring flag lost");
    property p_ri; $rose(ring_indicate) |=> ring_wake; endproperty
    a_ri: assert property (p_ri) else $error("ring edge missed");
    property p_ri_src;
        $rose(ring_wake) |-> $past(ring_indicate) && !$past(ring_indicate, 2);
    endproperty
    a_ri_src: assert property (p_ri_src) else $error("ring flag without edge");
    property p_irq_up; $rose(irq) |-> $past(wr || ev || ring_indicate); endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq without cause");
    property p_irq_dn; $fell(irq) |-> $past(wr); endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("irq dropped alone");
endmodule // uesf_chk
bind uesf_status uesf_chk u_chk (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .setup_rcvd        (setup_rcvd),
    .ring_indicate     (ring_indicate),
    .remote_wakeup_evt (remote_wakeup_evt),
    .resume_evt        (resume_evt),
    .suspend_evt       (suspend_evt),
    .port_reset_evt    (port_reset_evt),
    .ep0_force_nak     (ep0_force_nak),
    .ring_wake         (ring_wake),
    .irq               (irq)
);

/* File: testbench/tb_usb_event_status_flags.sv */
// Bench for the event status block; drives APB and event pins directly.
`timescale 1ns/100ps
`include "uesf_defs_defs.vh"
module tb_usb_event_status_flags;
    localparam logic [17:0] st_a = {`UESF_IDX_STATUS, 2'b00};
    localparam logic [17:0] mk_a = {`UESF_IDX_MASK, 2'b00};
    logic e;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic setup_rcvd = 0, remote_wakeup_evt = 0, ring_indicate = 0, resume_evt = 0;
    logic suspend_evt = 0, port_reset_evt = 0, ep0_force_nak, ring_wake, irq;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    int checks = 0, err_count = 0;
    uesf_status dut (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .setup_rcvd        (setup_rcvd),
        .remote_wakeup_evt (remote_wakeup_evt),
        .ring_indicate     (ring_indicate),
        .resume_evt        (resume_evt),
        .suspend_evt       (suspend_evt),
        .port_reset_evt    (port_reset_evt),
        .ep0_force_nak     (ep0_force_nak),
        .ring_wake         (ring_wake),
        .irq               (irq)
    );
    always #2 pclk = ~pclk;
    // One APB transfer; holds the request until pready is seen high.
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge pclk) {port_reset_evt, suspend_evt, resume_evt, ring_indicate,
            remote_wakeup_evt, setup_rcvd} <= v;
        @(posedge pclk) {port_reset_evt, suspend_evt, resume_evt, ring_indicate,
            remote_wakeup_evt, setup_rcvd} <= 6'h00;
    endtask
    task automatic chk(input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        #20000 err_count++;
        close_out;
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(0, st_a, 0); chk(r, 8'h00);
        chk(e, 0);
        apb(0, mk_a, 0); chk(r, 8'h00);
        $display("reset test done");
        apb(1, mk_a, 8'hff); apb(0, mk_a, 0); chk(r, 8'hef);
        pulse(6'h3f); pulse(6'h01);
        apb(0, st_a, 0); chk(r, 8'hef);
        chk(irq, 1); chk(ep0_force_nak, 1); chk(ring_wake, 1);
        apb(1, st_a, 0); apb(0, st_a, 0); chk(r, 8'hef);
        apb(1, st_a, 8'h04); apb(0, st_a, 0); chk(r, 8'heb);
        chk(ep0_force_nak, 0);
        apb(1, st_a, 8'hff); apb(0, st_a, 0); chk(irq, 0);
        $display("event test done");
        apb(1, mk_a, 0); pulse(6'h10);
        apb(0, st_a, 0); chk(r, 8'h40);
        chk(irq, 0);
        apb(0, 18'h0_0000, 0); chk(r, 8'h00);
        chk(e, 1);
        $display("mask test done");
        close_out;
    end
endmodule // tb_usb_event_status_flags
